// ==== design/backup_clock_pkg.sv ====
// constants, field layout and bus carrier for the backup clock block
// assumes a 32-bit avalon-mm master on clk_sys and byte addresses
package backup_clock_pkg;

    // ------------------------------------------------------------
    // register and memory map, byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] flag_addr = 32'hffffe700;
    localparam logic [31:0] ctrl_addr = 32'hffffe704;
    localparam logic [31:0] acc_addr = 32'hffffe708;
    localparam logic [31:0] ram_base = 32'hffffe800;
    localparam logic [31:0] ram_last = 32'hffffe9ff;
    localparam int ram_bytes = 512;
    localparam int ram_words = ram_bytes / 4;
    localparam int ram_index_w = 7;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int run_pos = 0;
    localparam int sel_pos = 1;
    localparam int clear_pos = 3;
    localparam int spare_pos = 6;
    localparam int flag_pos = 0;
    localparam logic [1:0] sel_reset = 2'h0;
    localparam logic [1:0] spare_reset = 2'h0;
    localparam logic [31:0] acc_reset = 32'h0;
    localparam logic [3:0] full_word = 4'hf;

    // ------------------------------------------------------------
    // timing: bus answer latency in clk_sys cycles, tick divider width and full count
    // ------------------------------------------------------------
    localparam logic [3:0] ram_cycles = 4'ha;
    localparam logic [3:0] reg_cycles = 4'h2;
    localparam int div_w = 15;
    localparam logic [14:0] div_full = 15'h7fff;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        bus_idle = 3'b001,
        bus_wait = 3'b010,
        bus_ack = 3'b100
    } bus_state_e;

    typedef struct packed {
        logic read;
        logic write;
        logic [31:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avmm_req_s;

endpackage

// ==== design/retention_ram.sv ====
// 128 x 32 retention memory with byte lanes
// assumes writes are already qualified by the bus logic
module retention_ram
    import backup_clock_pkg::*;
(
    input wire logic clk_sys,
    input wire logic ce,
    input wire logic we,
    input wire logic [3:0] byte_en,
    input wire logic [ram_index_w-1:0] index,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata
);
    // no reset on purpose: contents survive every reset
    // one bank per byte lane, so every bank has a single writer
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++)
        begin : g_lane
            logic [7:0] bank [ram_words];

            always_ff @(posedge clk_sys)
            begin
                if (ce && we && byte_en[lane])
                begin
                    bank[index] <= wdata[lane*8 +: 8];
                end
            end

            // read path is plain; the caller registers it
            assign rdata[lane*8 +: 8] = bank[index];
        end
    endgenerate

endmodule

// ==== design/backup_clock_timer_ram.sv ====
// backup domain: retention memory plus periodic tick timer
// assumes rst_n is the backup-domain reset, main_reset_n the system
// reset, and lf_clk_pin the free running 32.768 khz oscillator
//
// The implementer's own choice: the Avalon-MM interface to the registers.
module backup_clock_timer_ram
    import backup_clock_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic main_reset_n,
    input wire logic lf_clk_pin,
    input wire backup_clock_pkg::avmm_req_s bus_req,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic tick_interrupt
);
    import backup_clock_pkg::*;

    // ------------------------------------------------------------
    // low-frequency clock sampling
    // ------------------------------------------------------------
    logic lf_s1;
    logic lf_s2;
    logic lf_s3;
    logic lf_level;
    logic lf_tick;

    // three stages; a level counts once stages two and three agree
    // needs only clk_sys, so the timer keeps going
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lf_s1 <= 1'b0;
            lf_s2 <= 1'b0;
            lf_s3 <= 1'b0;
            lf_level <= 1'b0;
        end
        else if (ce)
        begin
            lf_s1 <= lf_clk_pin;
            lf_s2 <= lf_s1;
            lf_s3 <= lf_s2;
            if (lf_s2 == lf_s3)
            begin
                lf_level <= lf_s3;
            end
        end
    end

    // one pulse per accepted rising oscillator edge
    assign lf_tick = lf_s2 & lf_s3 & ~lf_level;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic req;
    logic sel_flag;
    logic sel_ctrl;
    logic sel_acc;
    logic sel_ram;
    logic word_wide;
    logic [31:0] addr;
    logic [31:0] wd;

    assign addr = bus_req.address;
    assign wd = bus_req.writedata;
    assign req = bus_req.read | bus_req.write;
    assign word_wide = (bus_req.byteenable == full_word);

    // unmapped addresses fall through: read zero, writes dropped
    always_comb
    begin
        sel_flag = 1'b0;
        sel_ctrl = 1'b0;
        sel_acc = 1'b0;
        sel_ram = 1'b0;
        if (addr == flag_addr)
        begin
            sel_flag = 1'b1;
        end
        else if (addr == ctrl_addr)
        begin
            sel_ctrl = 1'b1;
        end
        else if (addr == acc_addr)
        begin
            sel_acc = 1'b1;
        end
        else if (addr >= ram_base && addr <= ram_last)
        begin
            sel_ram = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    bus_state_e state;
    bus_state_e next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [31:0] next_readdata;
    logic [31:0] rd_value;
    logic [3:0] lat_m2;
    logic capture;
    logic commit;

    // memory answers slowly; registers answer one cycle later
    assign lat_m2 = sel_ram ? ram_cycles - 4'h2 : reg_cycles - 4'h2;

    // count cycles of the held request, then one cycle of answer
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        capture = 1'b0;
        case (state)
            bus_idle:
            begin
                if (req)
                begin
                    if (lat_m2 == 4'h0)
                    begin
                        capture = 1'b1;
                        next_state = bus_ack;
                    end
                    else
                    begin
                        next_cnt = 4'h1;
                        next_state = bus_wait;
                    end
                end
            end
            bus_wait:
            begin
                if (cnt == lat_m2)
                begin
                    capture = 1'b1;
                    next_state = bus_ack;
                end
                else
                begin
                    next_cnt = cnt + 4'h1;
                end
            end
            bus_ack:
            begin
                next_state = bus_idle;
                next_cnt = 4'h0;
            end
            default:
            begin
                next_state = bus_idle;
                next_cnt = 4'h0;
            end
        endcase
        // system reset abandons a transfer but keeps all stored state
        if (!main_reset_n)
        begin
            next_state = bus_idle;
            next_cnt = 4'h0;
            capture = 1'b0;
        end
        next_readdata = capture ? rd_value : readdata;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= bus_idle;
            cnt <= 4'h0;
            readdata <= 32'h0;
        end
        else if (ce)
        begin
            state <= next_state;
            cnt <= next_cnt;
            readdata <= next_readdata;
        end
    end

    assign waitrequest = req & (state != bus_ack);
    assign commit = bus_req.write & (state == bus_ack) & main_reset_n;

    // ------------------------------------------------------------
    // retention memory
    // ------------------------------------------------------------
    logic [31:0] ram_rdata;

    // memory has no reset input at all
    retention_ram u_ram (
        .clk_sys(clk_sys),
        .ce(ce),
        .we(commit & sel_ram),
        .byte_en(bus_req.byteenable),
        .index(addr[ram_index_w+1:2]),
        .wdata(wd),
        .rdata(ram_rdata)
    );

    // ------------------------------------------------------------
    // timer registers
    // ------------------------------------------------------------
    logic run;
    logic next_run;
    logic [1:0] sel;
    logic [1:0] next_sel;
    logic [1:0] spare;
    logic [1:0] next_spare;
    logic flag;
    logic next_flag;
    logic [31:0] acc;
    logic [31:0] next_acc;
    logic [div_w-1:0] div;
    logic [div_w-1:0] next_div;
    logic next_irq;
    logic [div_w-1:0] period_mask;
    logic expire;
    logic wr_ctrl;
    logic wr_acc;
    logic wr_flag;

    // partial-word writes to timer registers are dropped
    assign wr_ctrl = commit & sel_ctrl & word_wide;
    assign wr_acc = commit & sel_acc & word_wide;
    assign wr_flag = commit & sel_flag & word_wide;

    // shorter period keeps fewer low divider bits
    assign period_mask = div_full >> sel;
    assign expire = lf_tick & run & ((div & period_mask) == period_mask);

    always_comb
    begin
        next_run = run;
        next_sel = sel;
        next_spare = spare;
        next_flag = flag;
        next_acc = acc;
        next_div = div;
        next_irq = expire;
        if (!run)
        begin
            next_div = '0;
        end
        else if (lf_tick)
        begin
            next_div = div + 15'h1;
        end
        if (expire)
        begin
            next_acc = acc + 32'h1;
        end
        if (wr_ctrl)
        begin
            next_run = wd[run_pos];
            next_sel = wd[sel_pos +: 2];
            next_spare = wd[spare_pos +: 2];
            if (!wd[clear_pos])
            begin
                next_acc = acc_reset;
            end
        end
        if (wr_acc)
        begin
            next_acc = wd;
            next_div = '0;
        end
        if (wr_flag && wd[flag_pos])
        begin
            next_flag = 1'b1;
        end
    end

    // only the backup reset clears these
    // nothing is promised before the first one
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run <= 1'b0;
            sel <= sel_reset;
            spare <= spare_reset;
            flag <= 1'b0;
            acc <= acc_reset;
            div <= '0;
            tick_interrupt <= 1'b0;
        end
        else if (ce)
        begin
            run <= next_run;
            sel <= next_sel;
            spare <= next_spare;
            flag <= next_flag;
            acc <= next_acc;
            div <= next_div;
            tick_interrupt <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // clear bit reads one; bits 5:4 and above 7 read zero
    always_comb
    begin
        rd_value = 32'h0;
        if (sel_flag)
        begin
            rd_value[flag_pos] = flag;
        end
        else if (sel_ctrl)
        begin
            rd_value[run_pos] = run;
            rd_value[sel_pos +: 2] = sel;
            rd_value[clear_pos] = 1'b1;
            rd_value[spare_pos +: 2] = spare;
        end
        else if (sel_acc)
        begin
            rd_value = acc;
        end
        else if (sel_ram)
        begin
            rd_value = ram_rdata;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n || !ce || !main_reset_n);

    sequence ram_start;
        state == bus_idle && req && sel_ram;
    endsequence

    sequence ram_answer;
        waitrequest ##1 !waitrequest;
    endsequence

    a_ram_ten_cycles: assert property (
        ram_start |-> ##8 ram_answer)
        else $error("memory access not answered in ten cycles");

    a_reg_one_wait: assert property (
        state == bus_idle && req && !sel_ram |=> !waitrequest)
        else $error("register access not answered next cycle");

    a_clear_reads_one: assert property (
        state == bus_ack && bus_req.read && sel_ctrl
        |-> readdata[clear_pos] && readdata[5:4] == 2'h0)
        else $error("control read shows wrong fixed bits");

    a_acc_clear_word: assert property (
        wr_ctrl && !wd[clear_pos] && !wr_acc |=> acc == 32'h0)
        else $error("accumulator not cleared");

    a_acc_counts_up: assert property (
        expire && !wr_ctrl && !wr_acc
        |=> acc == $past(acc) + 32'h1)
        else $error("accumulator missed an expiry");

    a_irq_on_expiry: assert property (
        expire |=> tick_interrupt ##1 !tick_interrupt || expire)
        else $error("interrupt pulse wrong");

    a_flag_holds_set: assert property (
        flag |=> flag)
        else $error("monitor flag cleared without backup reset");

    a_stop_clears_div: assert property (
        !run && !wr_acc |=> div == '0)
        else $error("divider not held cleared while stopped");

    a_partial_dropped: assert property (
        commit && sel_ctrl && !word_wide |=> $stable({run, sel, spare}))
        else $error("partial write changed control");

    a_acc_write_div: assert property (
        wr_acc |=> div == '0 && acc == $past(wd))
        else $error("accumulator write did not clear divider");

endmodule

// ==== bench/backup_clock_timer_ram_test.sv ====
// self-checking bench for the backup clock timer and retention memory
// assumes the design package and an avalon-mm answer as in the hand-over
module backup_clock_timer_ram_test
    import backup_clock_pkg::*;
;
timeunit 1ns;
timeprecision 100ps;

// ------------------------------------------------------------
// stimulus signals and bookkeeping
// ------------------------------------------------------------
logic clk_sys = 1'b0;
logic rst_n = 1'b0;
logic ce = 1'b1;
logic main_reset_n = 1'b1;
logic [2:0] lf_div = 3'h0;
wire logic lf_clk_pin;
avmm_req_s bus_req = '0;
logic [31:0] readdata;
logic waitrequest;
logic tick_interrupt;
int errors = 0;
int check_count = 0;
int cycle_count = 0;
logic [31:0] exp_q[$];
int pulse_at[$];
logic [31:0] shadow [ram_words];

backup_clock_timer_ram dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .main_reset_n(main_reset_n),
    .lf_clk_pin(lf_clk_pin),
    .bus_req(bus_req),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .tick_interrupt(tick_interrupt)
);

// clock; oscillator sped up to one tick per 8 clocks to keep runs short
always #12.5 clk_sys = ~clk_sys;
always @(posedge clk_sys) lf_div <= lf_div + 3'h1;
assign lf_clk_pin = lf_div[2];

// ------------------------------------------------------------
// compare tasks, verdict and hang guard
// ------------------------------------------------------------
task automatic check_data(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
begin
    check_count++;
    if (got !== exp)
    begin
        errors++;
        $display("wrong value %s expected %h seen %h", what, exp, got);
    end
end
endtask

task automatic check_cycles(input string what, input int lo, input int hi,
                            input int got);
begin
    check_count++;
    if (got < lo || got > hi)
    begin
        errors++;
        $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi,
                 got);
    end
end
endtask

task automatic wrap_up();
begin
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
end
endtask

// ceiling: a 20000-cycle wait, two shortest periods, bus traffic
always @(posedge clk_sys)
begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 95000)
    begin
        errors++;
        wrap_up();
    end
end

// ------------------------------------------------------------
// watchers: read data against oldest note, interrupt pulse times
// ------------------------------------------------------------
// sampled at the edge, before that edge's own updates land
always @(posedge clk_sys)
begin
    if (rst_n && bus_req.read && waitrequest === 1'b0)
    begin
        if (exp_q.size() == 0)
        begin
            errors++;
            $display("wrong value readdata expected none seen %h", readdata);
        end
        else
            check_data("readdata", exp_q.pop_front(), readdata);
    end
    if (tick_interrupt === 1'b1)
        pulse_at.push_back(cycle_count);
end

// ------------------------------------------------------------
// bus master: holds the request up to the edge that sees waitrequest low
// ------------------------------------------------------------
task automatic bus_xfer(input logic is_wr, input logic [31:0] a,
                        input logic [31:0] d, input logic [3:0] be,
                        output int lat);
begin
    lat = 0;
    @(posedge clk_sys);
    bus_req.read <= ~is_wr;
    bus_req.write <= is_wr;
    bus_req.address <= a;
    bus_req.writedata <= d;
    bus_req.byteenable <= be;
    // right after the edge waitrequest still shows the ended cycle
    do
    begin
        @(posedge clk_sys);
        lat++;
    end while (waitrequest !== 1'b0 && lat < 200);
    if (waitrequest !== 1'b0)
    begin
        errors++;
        $display("wrong value waitrequest expected 0 seen %b", waitrequest);
    end
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
end
endtask

task automatic wr(input logic [31:0] a, input logic [31:0] d,
                  input logic [3:0] be);
    int lat;
begin
    bus_xfer(1'b1, a, d, be, lat);
end
endtask

task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    int lat;
begin
    exp_q.push_back(exp);
    bus_xfer(1'b0, a, 32'h0, full_word, lat);
end
endtask

// ------------------------------------------------------------
// main sequence
// ------------------------------------------------------------
initial
begin
    int lat;
    int idx;
    int t0;
    logic [31:0] d1;
    logic [31:0] d2;
    logic [3:0] be;
    void'($urandom(32'h0ce08471));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    // registers after backup reset, clear bit reads one
    rd(flag_addr, 32'h0);
    rd(ctrl_addr, 32'h8);
    rd(acc_addr, 32'h0);
    // monitor flag: partial word dropped, one sets, zero ignored
    wr(flag_addr, 32'h1, 4'h1);
    rd(flag_addr, 32'h0);
    wr(flag_addr, 32'h1, full_word);
    wr(flag_addr, 32'h0, full_word);
    rd(flag_addr, 32'h1);
    // every period code read back, timer kept stopped
    for (int s = 0; s < 4; s++)
    begin
        wr(ctrl_addr, 32'h8 | (s << 1), full_word);
        rd(ctrl_addr, 32'h8 | (s << 1));
    end
    wr(ctrl_addr, 32'hfffffff6, full_word);
    rd(ctrl_addr, 32'hce);
    wr(ctrl_addr, 32'h0, 4'he);
    rd(ctrl_addr, 32'hce);
    // accumulator: full write, partial write dropped, clear bit zero
    wr(acc_addr, 32'h12345678, full_word);
    wr(acc_addr, 32'h0, 4'h3);
    rd(acc_addr, 32'h12345678);
    wr(ctrl_addr, 32'h0, full_word);
    rd(acc_addr, 32'h0);
    // unmapped places read zero
    rd(32'hffffe70c, 32'h0);
    rd(ram_last + 32'h1, 32'h0);
    // retention memory: both ends plus random words, byte lanes merged
    // memory traffic in this loop at full speed; the stretched read follows
    for (int i = 0; i < 12; i++)
    begin
        idx = (i == 0) ? 0 : (i == 1) ? ram_words - 1 : $urandom % ram_words;
        d1 = $urandom;
        d2 = $urandom;
        be = 4'($urandom);
        bus_xfer(1'b1, ram_base + 4 * idx, d1, full_word, lat);
        check_cycles("ram write cycles", 10, 10, lat);
        bus_xfer(1'b1, ram_base + 4 * idx, d2, be, lat);
        for (int b = 0; b < 4; b++)
            if (be[b])
                d1[8*b +: 8] = d2[8*b +: 8];
        shadow[idx] = d1;
        exp_q.push_back(d1);
        bus_xfer(1'b0, ram_base + 4 * idx, 32'h0, full_word, lat);
        check_cycles("ram read cycles", 10, 10, lat);
    end
    // clock enable low for three cycles stretches a memory read
    exp_q.push_back(shadow[idx]);
    fork
        bus_xfer(1'b0, ram_base + 4 * idx, 32'h0, full_word, lat);
        begin
            repeat (3) @(posedge clk_sys);
            ce <= 1'b0;
            repeat (3) @(posedge clk_sys);
            ce <= 1'b1;
        end
    join
    check_cycles("stretched read cycles", 13, 13, lat);
    // values that only a backup reset may clear
    wr(acc_addr, 32'h5a5a5a5a, full_word);
    wr(ctrl_addr, 32'h4c, full_word);
    // system reset keeps memory and timer registers
    @(posedge clk_sys);
    main_reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    main_reset_n <= 1'b1;
    rd(ram_base, shadow[0]);
    rd(ram_last - 32'h3, shadow[ram_words-1]);
    rd(flag_addr, 32'h1);
    rd(acc_addr, 32'h5a5a5a5a);
    rd(ctrl_addr, 32'h4c);
    // second backup reset in mid-run returns registers to zero
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(flag_addr, 32'h0);
    rd(ctrl_addr, 32'h8);
    rd(acc_addr, 32'h0);
    // timer: shortest period; no pulse before a full period
    wr(ctrl_addr, 32'he, full_word);
    wr(ctrl_addr, 32'hf, full_word);
    repeat (20000) @(posedge clk_sys);
    check_cycles("early pulses", 0, 0, pulse_at.size());
    // accumulator write mid-period restarts the divider
    wr(acc_addr, 32'hffffffff, full_word);
    t0 = cycle_count;
    for (int k = 0; k < 40000 && pulse_at.size() < 1; k++)
        @(posedge clk_sys);
    check_cycles("first pulse", 32760, 32800, pulse_at[0] - t0);
    // no handler runs here while the accumulator is read
    rd(acc_addr, 32'h0);
    for (int k = 0; k < 40000 && pulse_at.size() < 2; k++)
        @(posedge clk_sys);
    check_cycles("period", 32768, 32768, pulse_at[1] - pulse_at[0]);
    rd(acc_addr, 32'h1);
    // stopping keeps the period choice and produces no further pulse
    wr(ctrl_addr, 32'he, full_word);
    rd(ctrl_addr, 32'he);
    check_cycles("pulse count", 2, 2, pulse_at.size());
    repeat (4) @(posedge clk_sys);
    check_cycles("unanswered reads", 0, 0, exp_q.size());
    wrap_up();
end

endmodule
